//--- zone_ramp_defs.svh
`ifndef ZONE_RAMP_DEFS_SVH
`define ZONE_RAMP_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_KHZ 25000
`define RAMP_TICK_MS 600

// ****************************************************************
// Register word indices inside one loop block
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_TARGET 4'h1
`define REG_HOLD 4'h2
`define REG_RATE 4'h3
`define REG_P 4'h4
`define REG_I 4'h5
`define REG_D 4'h6
`define REG_MHP 4'h7
`define REG_RANGE 4'h8
`define REG_ACTIVE_SP 4'h9
`define REG_STATUS 4'hA
`define ZONE_REGION 2'h1

// ****************************************************************
// Zone table field indices
// ****************************************************************
`define ZF_LIMIT 3'h0
`define ZF_P 3'h1
`define ZF_I 3'h2
`define ZF_D 3'h3
`define ZF_MHP 3'h4
`define ZF_RANGE 3'h5
`define NUM_ZONES 4'hA
`define ZONE_NONE 4'hF

// ****************************************************************
// Bit positions
// ****************************************************************
`define CTRL_ZONE_EN 0
`define CTRL_RAMP_EN 1
`define CTRL_UNITS_TEMP 2
`define ST_RAMPING 0
`define ST_HEATER_OFF 1

// ****************************************************************
// Limits and reset values (P, I in tenths, MANUAL_OUTPUT_OFFSET in 0.001 %)
// ****************************************************************
`define P_MAX 32'h00002710
`define I_MAX 32'h00002710
`define D_MAX 32'h000000C8
`define MHP_MAX 32'h000186A0
`define RANGE_MAX 32'h00000002
`define RATE_MAX 32'h000003E8
`define LIMIT_MAX 32'h000F4240
`define P_RST 14'h01F4
`define I_RST 14'h00C8
`define D_RST 8'h00
`define MHP_RST 17'h00000
`define LIMIT_RST 20'h00000
`define SP_FINE_LIMIT 32'sh000186A0
`define SP_COARSE_STEP 32'sh0000000A

`endif

//--- zone_ramp_pkg.sv
`default_nettype none
package zone_ramp_pkg;

   typedef enum logic [1:0] {
      RANGE_OFF = 2'b00,
      RANGE_LOW = 2'b01,
      RANGE_HIGH = 2'b10
   } heater_range_e;

   typedef struct packed {
      logic [19:0] limit;
      logic [13:0] p;
      logic [13:0] i;
      logic [7:0] d;
      logic [16:0] manual_output_offset;
      logic [1:0] range;
   } zone_entry_s;

   typedef struct packed {
      logic signed [31:0] reading_temp;
      logic signed [31:0] reading_sensor;
      logic curve_ok;
      logic [19:0] curve_limit;
      logic input_change;
   } loop_in_s;

   typedef struct packed {
      logic signed [31:0] setpoint;
      logic [13:0] p;
      logic [13:0] i;
      logic [7:0] d;
      logic [16:0] manual_output_offset;
      logic [1:0] range;
      logic [3:0] zone;
      logic ramping;
      logic autotune_inhibit;
      logic heater_off;
   } loop_out_s;

   typedef struct packed {
      logic hit;
      logic zone;
      logic loop;
      logic [3:0] zidx;
      logic [3:0] field;
   } addr_dec_s;

   typedef logic [9:0][19:0] limit_vec_t;

endpackage
`default_nettype wire

//--- zone_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "zone_ramp_defs.svh"

module zone_select (
   input wire zone_ramp_pkg::limit_vec_t limits,
   input wire logic signed [31:0] setpoint,
   output logic hit,
   output logic [3:0] zone
);

   // Scan from the lowest zone; a zero limit ends the valid table
   always_comb begin
      logic stop;
      stop = 1'b0;
      hit = 1'b0;
      zone = `ZONE_NONE;
      for (int z = 0; z < 10; z++) begin
         if (!stop) begin
            if (limits[z] == 20'h00000) begin
               stop = 1'b1;
            end else if (!hit &&
                         $signed({12'h000, limits[z]}) >= setpoint) begin
               hit = 1'b1;
               zone = 4'(z);
            end
         end
      end
   end

endmodule

`default_nettype wire

//--- zone_setpoint_ramp_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "zone_ramp_defs.svh"

module zone_setpoint_ramp_control #(
   parameter int unsigned RAMP_TICK_CYCLES = `RAMP_TICK_MS * `CLK_KHZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire zone_ramp_pkg::loop_in_s [1:0] loop_in,
   output zone_ramp_pkg::loop_out_s [1:0] loop_out
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   function automatic zone_ramp_pkg::addr_dec_s decode(
      input logic [11:0] a
   );
      zone_ramp_pkg::addr_dec_s d;
      d = '0;
      if (a[1:0] != 2'b00) begin
         d.hit = 1'b0;
      end else if (a[11:10] == `ZONE_REGION) begin
         d.zone = 1'b1;
         d.loop = a[9];
         d.zidx = a[8:5];
         d.field = {1'b0, a[4:2]};
         d.hit = (a[8:5] < `NUM_ZONES) && (a[4:2] < `ZF_RANGE ||
                 (a[4:2] == `ZF_RANGE && !a[9]));
      end else if (a[11:7] == 5'h00) begin
         d.loop = a[6];
         d.field = a[5:2];
         d.hit = (a[5:2] <= `REG_STATUS) &&
                 !(a[5:2] == `REG_RANGE && a[6]);
      end else begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

   // Out-of-range writes saturate instead of being refused
   function automatic logic [31:0] clampu(
      input logic [31:0] v,
      input logic [31:0] mx
   );
      return (v > mx) ? mx : v;
   endfunction

   function automatic logic signed [31:0] sp_fix(
      input logic signed [31:0] v,
      input logic temp,
      input logic [19:0] lim
   );
      logic signed [31:0] r;
      r = v;
      if (temp) begin
         if (r > $signed({12'h000, lim})) begin
            r = $signed({12'h000, lim});
         end
         if (r < 32'sh0) begin
            r = 32'sh0;
         end
         if (r >= `SP_FINE_LIMIT) begin
            r = r - (r % `SP_COARSE_STEP);
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************

   zone_ramp_pkg::zone_entry_s zt_q [2][10];
   logic [1:0] zone_en_q, ramp_en_q, units_temp_q, heater_off_q;
   logic [9:0] rate_q [2];
   logic signed [31:0] sp_q [2];
   logic signed [31:0] target_q [2];
   logic [1:0] ramping_q;
   logic [13:0] p_q [2];
   logic [13:0] i_q [2];
   logic [7:0] d_q [2];
   logic [16:0] mhp_q [2];
   logic [1:0] range_q [2];
   logic [3:0] zone_q [2];
   logic [23:0] tick_cnt_q;
   logic tick_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;

   zone_ramp_pkg::addr_dec_s dec;
   logic wr_en;
   logic [1:0] wr_loop, wr_zone, no_curve, units_wr, zhit;
   logic [3:0] zidx [2];
   logic signed [31:0] sp_new [2];
   zone_ramp_pkg::limit_vec_t lim_pk [2];
   logic [31:0] rd_data;

   // ****************************************************************
   // APB slave
   // ****************************************************************

   assign dec = decode(paddr);
   assign wr_en = psel && penable && pready_q && pwrite && dec.hit;

   // Answer in the first access cycle; read data latched in setup
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= psel && !penable && !pready_q;
         // Error stands only with the one-cycle answer
         pslverr_q <= psel && !penable && !pready_q && !dec.hit;
         if (psel && !penable) begin
            prdata_q <= dec.hit ? rd_data : 32'h00000000;
         end
      end
   end

   // Read multiplexer
   always_comb begin
      rd_data = 32'h00000000;
      if (dec.zone) begin
         if (dec.field == {1'b0, `ZF_LIMIT}) begin
            rd_data = {12'h000, zt_q[dec.loop][dec.zidx].limit};
         end else if (dec.field == {1'b0, `ZF_P}) begin
            rd_data = {18'h00000, zt_q[dec.loop][dec.zidx].p};
         end else if (dec.field == {1'b0, `ZF_I}) begin
            rd_data = {18'h00000, zt_q[dec.loop][dec.zidx].i};
         end else if (dec.field == {1'b0, `ZF_D}) begin
            rd_data = {24'h000000, zt_q[dec.loop][dec.zidx].d};
         end else if (dec.field == {1'b0, `ZF_MHP}) begin
            rd_data = {15'h0000, zt_q[dec.loop][dec.zidx].manual_output_offset};
         end else begin
            rd_data = {30'h00000000, zt_q[dec.loop][dec.zidx].range};
         end
      end else if (dec.field == `REG_CTRL) begin
         rd_data = {29'h00000000, units_temp_q[dec.loop],
                    ramp_en_q[dec.loop], zone_en_q[dec.loop]};
      end else if (dec.field == `REG_TARGET) begin
         rd_data = target_q[dec.loop];
      end else if (dec.field == `REG_RATE) begin
         rd_data = {22'h000000, rate_q[dec.loop]};
      end else if (dec.field == `REG_P) begin
         rd_data = {18'h00000, p_q[dec.loop]};
      end else if (dec.field == `REG_I) begin
         rd_data = {18'h00000, i_q[dec.loop]};
      end else if (dec.field == `REG_D) begin
         rd_data = {24'h000000, d_q[dec.loop]};
      end else if (dec.field == `REG_MHP) begin
         rd_data = {15'h0000, mhp_q[dec.loop]};
      end else if (dec.field == `REG_RANGE) begin
         rd_data = {30'h00000000, range_q[dec.loop]};
      end else if (dec.field == `REG_ACTIVE_SP) begin
         rd_data = sp_q[dec.loop];
      end else if (dec.field == `REG_STATUS) begin
         rd_data = {24'h000000, zone_q[dec.loop], 2'b00,
                    heater_off_q[dec.loop], ramping_q[dec.loop]};
      end
   end

   // ****************************************************************
   // Per-loop event terms
   // ****************************************************************

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         wr_loop[l] = wr_en && !dec.zone && dec.loop == 1'(l);
         wr_zone[l] = wr_en && dec.zone && dec.loop == 1'(l);
         no_curve[l] = !loop_in[l].curve_ok && units_temp_q[l];
         units_wr[l] = wr_loop[l] && dec.field == `REG_CTRL &&
            (pwdata[`CTRL_UNITS_TEMP] && loop_in[l].curve_ok) !=
            units_temp_q[l];
         sp_new[l] = sp_fix(pwdata, units_temp_q[l],
                            loop_in[l].curve_limit);
         for (int z = 0; z < 10; z++) begin
            lim_pk[l][z] = zt_q[l][z].limit;
         end
      end
   end

   // Independent zone search for each loop
   for (genvar g = 0; g < 2; g++) begin : g_sel
      zone_select u_sel (
         .limits(lim_pk[g]),
         .setpoint(sp_q[g]),
         .hit(zhit[g]),
         .zone(zidx[g])
      );
   end

   // ****************************************************************
   // Ramp time base
   // ****************************************************************

   // Shared tick: one step of rate_q milli-units per 1/100 minute
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_cnt_q <= 24'h000000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q >= 24'(RAMP_TICK_CYCLES - 1)) begin
         tick_cnt_q <= 24'h000000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 24'h000001;
         tick_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Zone table
   // ****************************************************************

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int l = 0; l < 2; l++) begin
            for (int z = 0; z < 10; z++) begin
               zt_q[l][z].limit <= `LIMIT_RST;
               zt_q[l][z].p <= `P_RST;
               zt_q[l][z].i <= `I_RST;
               zt_q[l][z].d <= `D_RST;
               zt_q[l][z].manual_output_offset <= `MHP_RST;
               zt_q[l][z].range <= zone_ramp_pkg::RANGE_OFF;
            end
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (wr_zone[l]) begin
               if (dec.field == {1'b0, `ZF_LIMIT}) begin
                  zt_q[l][dec.zidx].limit <=
                     20'(clampu(pwdata, `LIMIT_MAX));
               end else if (dec.field == {1'b0, `ZF_P}) begin
                  zt_q[l][dec.zidx].p <= 14'(clampu(pwdata, `P_MAX));
               end else if (dec.field == {1'b0, `ZF_I}) begin
                  zt_q[l][dec.zidx].i <= 14'(clampu(pwdata, `I_MAX));
               end else if (dec.field == {1'b0, `ZF_D}) begin
                  zt_q[l][dec.zidx].d <= 8'(clampu(pwdata, `D_MAX));
               end else if (dec.field == {1'b0, `ZF_MHP}) begin
                  zt_q[l][dec.zidx].manual_output_offset <=
                     17'(clampu(pwdata, `MHP_MAX));
               end else begin
                  zt_q[l][dec.zidx].range <=
                     2'(clampu(pwdata, `RANGE_MAX));
               end
            end
         end
      end
   end

   // ****************************************************************
   // Control and status bits
   // ****************************************************************

   // Heater-off set by an input change wins over a same-cycle clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         zone_en_q <= 2'b00;
         ramp_en_q <= 2'b00;
         units_temp_q <= 2'b00;
         heater_off_q <= 2'b00;
         for (int l = 0; l < 2; l++) begin
            rate_q[l] <= 10'h000;
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (wr_loop[l] && dec.field == `REG_CTRL) begin
               zone_en_q[l] <= pwdata[`CTRL_ZONE_EN];
               ramp_en_q[l] <= pwdata[`CTRL_RAMP_EN];
               units_temp_q[l] <= pwdata[`CTRL_UNITS_TEMP] &&
                                  loop_in[l].curve_ok;
            end
            if (wr_loop[l] && dec.field == `REG_RATE) begin
               rate_q[l] <= 10'(clampu(pwdata, `RATE_MAX));
            end
            if (no_curve[l]) begin
               units_temp_q[l] <= 1'b0;
            end
            if (loop_in[l].input_change && ramping_q[l]) begin
               ramp_en_q[l] <= 1'b0;
            end
            if (loop_in[l].input_change) begin
               heater_off_q[l] <= 1'b1;
            end else if (wr_loop[l] && dec.field == `REG_STATUS &&
                         pwdata[`ST_HEATER_OFF]) begin
               heater_off_q[l] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Setpoint and ramp generator
   // ****************************************************************

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ramping_q <= 2'b00;
         for (int l = 0; l < 2; l++) begin
            sp_q[l] <= 32'sh0;
            target_q[l] <= 32'sh0;
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (no_curve[l]) begin
               sp_q[l] <= loop_in[l].reading_sensor;
               target_q[l] <= loop_in[l].reading_sensor;
               ramping_q[l] <= 1'b0;
            end else if (units_wr[l] && !heater_off_q[l]) begin
               // Restart from the reading in the new units
               sp_q[l] <= units_temp_q[l] ? loop_in[l].reading_sensor :
                          loop_in[l].reading_temp;
               target_q[l] <= units_temp_q[l] ?
                  loop_in[l].reading_sensor : loop_in[l].reading_temp;
               ramping_q[l] <= 1'b0;
            end else if (wr_loop[l] && dec.field == `REG_TARGET) begin
               target_q[l] <= sp_new[l];
               if (ramp_en_q[l] && units_temp_q[l] && rate_q[l] != 0) begin
                  ramping_q[l] <= sp_new[l] != sp_q[l];
               end else begin
                  sp_q[l] <= sp_new[l];
                  ramping_q[l] <= 1'b0;
               end
            end else if (wr_loop[l] && dec.field == `REG_HOLD) begin
               target_q[l] <= sp_q[l];
               ramping_q[l] <= 1'b0;
            end else if (ramping_q[l] && (!ramp_en_q[l] ||
                         !units_temp_q[l] || loop_in[l].input_change)) begin
               ramping_q[l] <= 1'b0;
            end else if (ramping_q[l] && tick_q) begin
               // Same magnitude for rising and falling ramps
               if (target_q[l] - sp_q[l] > $signed({22'h0, rate_q[l]})) begin
                  sp_q[l] <= sp_q[l] + $signed({22'h0, rate_q[l]});
               end else if (sp_q[l] - target_q[l] >
                            $signed({22'h0, rate_q[l]})) begin
                  sp_q[l] <= sp_q[l] - $signed({22'h0, rate_q[l]});
               end else begin
                  sp_q[l] <= target_q[l];
                  ramping_q[l] <= 1'b0;
               end
            end
         end
      end
   end

   // ****************************************************************
   // Active control parameters
   // ****************************************************************

   // Manual writes stick until the setpoint enters another zone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int l = 0; l < 2; l++) begin
            p_q[l] <= `P_RST;
            i_q[l] <= `I_RST;
            d_q[l] <= `D_RST;
            mhp_q[l] <= `MHP_RST;
            range_q[l] <= zone_ramp_pkg::RANGE_OFF;
            zone_q[l] <= `ZONE_NONE;
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (wr_loop[l] && dec.field == `REG_P) begin
               p_q[l] <= 14'(clampu(pwdata, `P_MAX));
            end else if (wr_loop[l] && dec.field == `REG_I) begin
               i_q[l] <= 14'(clampu(pwdata, `I_MAX));
            end else if (wr_loop[l] && dec.field == `REG_D) begin
               d_q[l] <= 8'(clampu(pwdata, `D_MAX));
            end else if (wr_loop[l] && dec.field == `REG_MHP) begin
               mhp_q[l] <= 17'(clampu(pwdata, `MHP_MAX));
            end else if (wr_loop[l] && dec.field == `REG_RANGE) begin
               range_q[l] <= 2'(clampu(pwdata, `RANGE_MAX));
            end else if (!zone_en_q[l] || !units_temp_q[l]) begin
               zone_q[l] <= `ZONE_NONE;
            end else if (zhit[l] && zidx[l] != zone_q[l]) begin
               p_q[l] <= zt_q[l][zidx[l]].p;
               i_q[l] <= zt_q[l][zidx[l]].i;
               d_q[l] <= zt_q[l][zidx[l]].d;
               mhp_q[l] <= zt_q[l][zidx[l]].manual_output_offset;
               range_q[l] <= (l == 0) ? zt_q[l][zidx[l]].range :
                             zone_ramp_pkg::RANGE_OFF;
               zone_q[l] <= zidx[l];
            end
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         loop_out[l].setpoint = sp_q[l];
         loop_out[l].p = p_q[l];
         loop_out[l].i = i_q[l];
         loop_out[l].d = d_q[l];
         loop_out[l].manual_output_offset = mhp_q[l];
         loop_out[l].range = range_q[l];
         loop_out[l].zone = zone_q[l];
         loop_out[l].ramping = ramping_q[l];
         loop_out[l].autotune_inhibit = ramping_q[l];
         loop_out[l].heater_off = heater_off_q[l];
      end
   end

endmodule

`default_nettype wire

//--- zone_select_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- zone_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the keypad and remote host on the bus
module zone_host_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // Call right after a rising edge; holds all until pready is seen
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data must not look valid
   endtask
endmodule
`default_nettype wire

//--- zone_ramp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module zone_ramp_checker #(
   parameter int unsigned RAMP_TICK_CYCLES = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire zone_ramp_pkg::loop_in_s [1:0] loop_in,
   input wire zone_ramp_pkg::loop_out_s [1:0] loop_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Bus handshake in two steps
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_answer;
      psel && penable && pready ##1 !pready;
   endsequence
   chk_ready_one_cycle: assert property (apb_setup |=> apb_answer)
      else $error("ready not single access cycle");
   chk_err_with_ready: assert property (pslverr |-> pready && penable)
      else $error("error outside access");
   chk_autotune_block: assert property (
      loop_out[0].autotune_inhibit == loop_out[0].ramping)
      else $error("autotune not inhibited");
   chk_heater_kill: assert property (
      loop_in[0].input_change |=> loop_out[0].heater_off)
      else $error("heater not shut off");
   chk_ramp_kill: assert property (
      loop_in[0].input_change && loop_out[0].ramping
      |=> !loop_out[0].ramping) else $error("ramp survived input change");
   chk_second_range: assert property (loop_out[1].range == 2'h0)
      else $error("second loop has heater range");
   chk_gain_bounds: assert property (
      loop_out[0].p <= 14'h2710 && loop_out[0].d <= 8'hC8
      && loop_out[0].manual_output_offset <= 17'h186A0) else $error("gain out of range");
   chk_reset_vals: assert property ($fell(sys_rst) |->
      loop_out[0].p == 14'h1F4 && loop_out[0].i == 14'hC8
      && loop_out[0].zone == 4'hF) else $error("bad reset values");
   chk_zone_index: assert property (
      loop_out[0].zone <= 4'h9 || loop_out[0].zone == 4'hF)
      else $error("zone index out of range");
endmodule
bind zone_setpoint_ramp_control zone_ramp_checker #(
   .RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)
) zone_ramp_checker_inst (.clk, .sys_rst, .psel, .penable, .pready,
   .pslverr, .loop_in, .loop_out);
`default_nettype wire

//--- zone_setpoint_ramp_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module zone_setpoint_ramp_control_tb_top;
   localparam logic [32:0] ERR = 33'h100000000;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   zone_ramp_pkg::loop_in_s [1:0] li;
   zone_ramp_pkg::loop_out_s [1:0] lo;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int failures, n_compared, cyc;
   // Short ramp tick keeps the run brief
   zone_setpoint_ramp_control #(.RAMP_TICK_CYCLES(40))
   zone_setpoint_ramp_control_inst (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .loop_in(li), .loop_out(lo));
   zone_host_model zone_host_model_inst (.clk(clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic print_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic bad(input logic [32:0] g, x);
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
   endtask
   // Reads meet their oldest note at the edge the answer is taken
   always @(posedge clk) begin
      cyc++;
      if (psel && penable && pready && !pwrite) begin
         e = exp_q.pop_front();
         n_compared++;
         if ({pslverr, prdata} !== e) bad({pslverr, prdata}, e);
      end
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      zone_host_model_inst.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      @(posedge clk);
      zone_host_model_inst.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wrd(input logic [11:0] a, input logic [31:0] d, x);
      wr(a, d);
      rd(a, {1'b0, x});
   endtask
   task automatic zset(input logic [11:0] a, input logic [31:0] l, p);
      wr(a, l);
      wr(a + 12'h004, p);
   endtask
   initial begin
      sys_rst = 1'b1;
      li = '0;
      li[0].reading_temp = 32'sh1F40;
      li[0].reading_sensor = 32'sh4D2;
      li[0].curve_ok = 1'b1;
      li[0].curve_limit = 20'h30D40;
      li[1] = li[0];
      v = $urandom(67444);
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd(12'h010, 33'h1F4);
      rd(12'h014, 33'hC8);
      rd(12'h018, 33'h0);
      rd(12'h01C, 33'h0);
      rd(12'h400, 33'h0);
      rd(12'h060, ERR);
      rd(12'h614, ERR);
      rd(12'h300, ERR);
      wrd(12'h010, 32'h4E20, 32'h2710);
      wrd(12'h018, 32'h12C, 32'hC8);
      wrd(12'h01C, 32'h30D40, 32'h186A0);
      wrd(12'h020, 32'h7, 32'h2);
      wrd(12'h00C, 32'h1388, 32'h3E8);
      repeat (3) begin
         v = $urandom % 32'h4E20;
         wrd(12'h014, v, (v > 32'h2710) ? 32'h2710 : v);
      end
      // Zones 0,1 live; zone 3 hidden behind empty zone 2
      zset(12'h400, 32'h2710, 32'h6F);
      zset(12'h420, 32'h4E20, 32'hDE);
      zset(12'h460, 32'hC350, 32'h1BC);
      wr(12'h000, 32'h5);
      rd(12'h024, 33'h1F40);
      rd(12'h010, 33'h6F);
      wr(12'h004, 32'h3A98);
      rd(12'h010, 33'hDE);
      rd(12'h028, 33'h10);
      wr(12'h004, 32'h9C40);
      rd(12'h010, 33'hDE);
      wr(12'h004, 32'h1E241);
      rd(12'h024, 33'h1E23A);
      wr(12'h004, 32'h3D090);
      rd(12'h024, 33'h30D40);
      wr(12'h004, 32'h1388);
      rd(12'h010, 33'h6F);
      wr(12'h010, 32'h14D);
      wr(12'h004, 32'h1770);
      rd(12'h010, 33'h14D);
      // Ramp up, down, pause, resume, switch off
      wr(12'h000, 32'h6);
      wr(12'h00C, 32'h5);
      wr(12'h004, 32'h177A);
      rd(12'h028, 33'hF1);
      repeat (150) @(posedge clk);
      rd(12'h024, 33'h177A);
      wr(12'h004, 32'h1388);
      rd(12'h028, 33'hF1);
      wr(12'h008, 32'h0);
      rd(12'h028, 33'hF0);
      wr(12'h004, 32'h1388);
      rd(12'h028, 33'hF1);
      wr(12'h000, 32'h4);
      repeat (2) @(posedge clk);
      v = lo[0].setpoint;
      repeat (100) @(posedge clk);
      n_compared++;
      if (lo[0].setpoint !== v || v <= 32'h1388) bad(lo[0].setpoint, v);
      // Input change in mid-ramp
      wr(12'h000, 32'h6);
      wr(12'h004, 32'h1B58);
      rd(12'h028, 33'hF1);
      @(posedge clk);
      li[0].input_change <= 1'b1;
      @(posedge clk);
      li[0].input_change <= 1'b0;
      rd(12'h028, 33'hF2);
      rd(12'h000, 33'h4);
      wr(12'h028, 32'h2);
      rd(12'h028, 33'hF0);
      // Sensor units: ramp enable kept, no ramping
      wr(12'h000, 32'h2);
      rd(12'h024, 33'h4D2);
      wr(12'h004, 32'h309);
      rd(12'h024, 33'h309);
      rd(12'h000, 33'h2);
      wr(12'h000, 32'h4);
      @(posedge clk);
      li[0].curve_ok <= 1'b0;
      rd(12'h000, 33'h0);
      rd(12'h024, 33'h4D2);
      zset(12'h600, 32'h186A0, 32'h63);
      wr(12'h040, 32'h5);
      rd(12'h050, 33'h63);
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule
`default_nettype wire
